/* edsp_window.sv */
`timescale 1ns/100ps
`include "edsp_cfg.svh"
// What this block does
// - Windowed read address is read page over offset
// - Windowed write address is write page over offset
// - Pages are 32 Kbytes, one per window
// - Program space view uses only read page
// - Windowed access to page zero traps, except under program space view
// - Windowed read takes two cycles
// - Repeat reads: first two three cycles, then one
// - Windowed write completes in one cycle
// - Offset rollover never changes page registers
// - Read-modify-write takes page from read page
// - Window reaches extra internal RAM and external port
// - Byte, word, double-word; stepping stays in page
// - Below window base, page registers ignored
module edsp_window #(
  parameter logic [`EDSP_XADDR_W-1:0] INT_LIMIT = `EDSP_INT_LIMIT
) (
  input  wire logic                        ref_clk,
  input  wire logic                        rstn,
  input  wire logic                        req_valid,
  input  wire logic                        req_write,
  input  wire logic                        req_rmw,
  input  wire logic                        req_repeat,
  input  wire logic [1:0]                  req_size,
  input  wire logic [`EDSP_EA_W-1:0]       req_ea,
  input  wire logic [`EDSP_PAGE_REG_W-1:0] data_read_page,
  input  wire logic [`EDSP_PAGE_REG_W-1:0] data_write_page,
  output logic                             req_ready_q,
  output logic [`EDSP_XADDR_W-1:0]         mem_addr_q,
  output logic                             mem_rd_q,
  output logic                             mem_wr_q,
  output logic                             mem_ext_q,
  output logic                             mem_psv_q,
  output logic [1:0]                       mem_size_q,
  output logic                             acc_done_q,
  output logic                             addr_err_trap_q
);

  // ========================================================================
  // Reset release
  logic [1:0] rst_pipe_q;
  logic       rst_n;
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      rst_pipe_q <= 2'h0;
    end else begin
      rst_pipe_q <= {rst_pipe_q[0], 1'b1};
    end
  end
  assign rst_n = rst_pipe_q[1];

  // ========================================================================
  // Helpers
  function automatic logic [1:0] beat_cycles(input logic rd, input logic win,
                                             input logic rpt, input logic [1:0] rcnt);
    if (!rd) begin
      beat_cycles = `EDSP_WR_CYC;
    end else if (!win) begin
      beat_cycles = `EDSP_NEAR_CYC;
    end else if (rpt) begin
      beat_cycles = (rcnt < `EDSP_RPT_SLOW_N) ? `EDSP_RPT_SLOW : `EDSP_RPT_FAST;
    end else begin
      beat_cycles = `EDSP_RD_CYC;
    end
  endfunction
  function automatic logic is_ext(input logic [`EDSP_XADDR_W-1:0] a);
    is_ext = (a >= INT_LIMIT);
  endfunction

  // ========================================================================
  // Access sequencer
  edsp_pkg::edsp_state_type st_q, st_d;
  logic                       ready_d, rd_d, wr_d, ext_d, psv_d, done_d, trap_d;
  logic [`EDSP_XADDR_W-1:0]   addr_d;
  logic [1:0]                 size_d;
  logic                       win_q, win_d;
  logic                       rmw_q, rmw_d;
  logic                       more_q, more_d;
  logic                       rpt_q, rpt_d;
  logic [1:0]                 rcnt_q, rcnt_d;
  logic [1:0]                 wait_q, wait_d;
  logic                       dir_wr_q, dir_wr_d;

  always_comb begin
    logic                          use_rd;
    logic [`EDSP_PAGE_REG_W-1:0]   pg;
    logic                          win;
    logic                          program_space_view;
    logic [1:0]                    cyc;
    logic [1:0]                    rc;
    use_rd  = 1'b0;
    pg      = '0;
    win     = 1'b0;
    program_space_view     = 1'b0;
    cyc     = `EDSP_WR_CYC;
    rc      = rcnt_q;
    st_d    = st_q;
    ready_d = req_ready_q;
    addr_d  = mem_addr_q;
    rd_d    = 1'b0;
    wr_d    = 1'b0;
    ext_d   = mem_ext_q;
    psv_d   = mem_psv_q;
    size_d  = mem_size_q;
    done_d  = 1'b0;
    trap_d  = 1'b0;
    win_d   = win_q;
    rmw_d   = rmw_q;
    more_d  = more_q;
    rpt_d   = rpt_q;
    rcnt_d  = rcnt_q;
    wait_d  = wait_q;
    dir_wr_d = dir_wr_q;
    unique case (st_q)
      edsp_pkg::EDSP_IDLE: begin
        if (req_valid) begin
          use_rd = !req_write || req_rmw;
          pg     = use_rd ? data_read_page : data_write_page;
          win    = req_ea[`EDSP_WIN_BIT];
          program_space_view    = win && use_rd && pg[`EDSP_PSV_BIT];
          rc     = req_repeat ? rcnt_q : 2'h0;
          rcnt_d = rc;
          if (win && !program_space_view && pg[`EDSP_PAGE_W-1:0] == `EDSP_PAGE_ZERO) begin
            trap_d = 1'b1;
            done_d = 1'b1;
          end else begin
            if (win) begin
              addr_d = {pg[`EDSP_PAGE_W-1:0], req_ea[`EDSP_OFS_W-1:0]};
            end else begin
              addr_d = {`EDSP_NEAR_PAD, req_ea};
            end
            ext_d  = is_ext(addr_d);
            psv_d  = program_space_view;
            size_d = req_size;
            rd_d   = use_rd;
            wr_d   = !use_rd;
            win_d  = win;
            rmw_d  = req_rmw;
            dir_wr_d = !use_rd;
            rpt_d  = req_repeat;
            more_d = req_rmw || (req_size == edsp_pkg::EDSP_DWORD);
            cyc    = beat_cycles(use_rd, win, req_repeat, rc);
            if (use_rd && win && req_repeat && rc < `EDSP_RPT_SLOW_N) begin
              rcnt_d = rc + 2'h1;
            end
            if (cyc != 2'h1) begin
              st_d    = edsp_pkg::EDSP_BUSY;
              wait_d  = cyc - 2'h2;
              ready_d = 1'b0;
            end else if (more_d) begin
              st_d    = edsp_pkg::EDSP_NEXT;
              ready_d = 1'b0;
            end else begin
              done_d = 1'b1;
            end
          end
        end
      end
      edsp_pkg::EDSP_BUSY: begin
        if (wait_q != 2'h0) begin
          wait_d = wait_q - 2'h1;
        end else if (more_q) begin
          st_d = edsp_pkg::EDSP_NEXT;
        end else begin
          st_d    = edsp_pkg::EDSP_IDLE;
          done_d  = 1'b1;
          ready_d = 1'b1;
        end
      end
      edsp_pkg::EDSP_NEXT: begin
        more_d = 1'b0;
        if (rmw_q) begin
          wr_d = 1'b1;
          cyc  = `EDSP_WR_CYC;
        end else begin
          // Second word wraps inside the page; upper bits never advance
          addr_d[`EDSP_OFS_W-1:0] = mem_addr_q[`EDSP_OFS_W-1:0] + `EDSP_DWORD_STEP;
          ext_d  = is_ext(addr_d);
          rd_d   = !dir_wr_q;
          wr_d   = !rd_d;
          cyc    = beat_cycles(rd_d, win_q, rpt_q, rcnt_q);
          if (rd_d && win_q && rpt_q && rcnt_q < `EDSP_RPT_SLOW_N) begin
            rcnt_d = rcnt_q + 2'h1;
          end
        end
        if (cyc != 2'h1) begin
          st_d   = edsp_pkg::EDSP_BUSY;
          wait_d = cyc - 2'h2;
        end else begin
          st_d    = edsp_pkg::EDSP_IDLE;
          done_d  = 1'b1;
          ready_d = 1'b1;
        end
      end
      default: begin
        st_d    = edsp_pkg::EDSP_IDLE;
        ready_d = 1'b1;
      end
    endcase
  end

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      st_q            <= edsp_pkg::EDSP_IDLE;
      req_ready_q     <= 1'b1;
      mem_addr_q      <= '0;
      mem_rd_q        <= 1'b0;
      mem_wr_q        <= 1'b0;
      mem_ext_q       <= 1'b0;
      mem_psv_q       <= 1'b0;
      mem_size_q      <= 2'h0;
      acc_done_q      <= 1'b0;
      addr_err_trap_q <= 1'b0;
      win_q           <= 1'b0;
      rmw_q           <= 1'b0;
      more_q          <= 1'b0;
      rpt_q           <= 1'b0;
      rcnt_q          <= 2'h0;
      wait_q          <= 2'h0;
      dir_wr_q        <= 1'b0;
    end else begin
      st_q            <= st_d;
      req_ready_q     <= ready_d;
      mem_addr_q      <= addr_d;
      mem_rd_q        <= rd_d;
      mem_wr_q        <= wr_d;
      mem_ext_q       <= ext_d;
      mem_psv_q       <= psv_d;
      mem_size_q      <= size_d;
      acc_done_q      <= done_d;
      addr_err_trap_q <= trap_d;
      win_q           <= win_d;
      rmw_q           <= rmw_d;
      more_q          <= more_d;
      rpt_q           <= rpt_d;
      rcnt_q          <= rcnt_d;
      wait_q          <= wait_d;
      dir_wr_q        <= dir_wr_d;
    end
  end

  // ========================================================================
  // Checks
  logic acc, plain, rd_win, wr_win;
  assign acc    = req_valid && st_q == edsp_pkg::EDSP_IDLE;
  assign plain  = req_size != edsp_pkg::EDSP_DWORD && !req_rmw;
  assign rd_win = acc && plain && !req_write && req_ea[`EDSP_WIN_BIT]
                  && !data_read_page[`EDSP_PSV_BIT] && data_read_page[8:0] != 9'h000;
  assign wr_win = acc && plain && req_write && req_ea[`EDSP_WIN_BIT]
                  && data_write_page[8:0] != 9'h000;
  property p_rd_addr;
    @(posedge ref_clk) disable iff (!rst_n)
    rd_win |=> mem_rd_q && mem_addr_q == {$past(data_read_page[8:0]), $past(req_ea[14:0])};
  endproperty
  a_rd_addr: assert property (p_rd_addr) else $error("windowed read address wrong");
  property p_wr_addr;
    @(posedge ref_clk) disable iff (!rst_n)
    wr_win |=> mem_wr_q && mem_addr_q == {$past(data_write_page[8:0]), $past(req_ea[14:0])};
  endproperty
  a_wr_addr: assert property (p_wr_addr) else $error("windowed write address wrong");
  property p_trap;
    @(posedge ref_clk) disable iff (!rst_n)
    acc && req_ea[15] && req_write && !req_rmw && data_write_page[8:0] == 9'h000
    |=> addr_err_trap_q && !mem_wr_q && !mem_rd_q;
  endproperty
  a_trap: assert property (p_trap) else $error("page zero did not trap");
  property p_rd2;
    @(posedge ref_clk) disable iff (!rst_n)
    rd_win && !req_repeat |=> !acc_done_q ##1 acc_done_q;
  endproperty
  a_rd2: assert property (p_rd2) else $error("windowed read not two cycles");
  property p_rpt3;
    @(posedge ref_clk) disable iff (!rst_n)
    rd_win && req_repeat && rcnt_q == 2'h0 |=> !acc_done_q [*2] ##1 acc_done_q;
  endproperty
  a_rpt3: assert property (p_rpt3) else $error("first repeat read not three cycles");
  property p_wr1;
    @(posedge ref_clk) disable iff (!rst_n)
    wr_win |=> acc_done_q && req_ready_q;
  endproperty
  a_wr1: assert property (p_wr1) else $error("windowed write not single cycle");
  property p_near;
    @(posedge ref_clk) disable iff (!rst_n)
    acc && !req_ea[15] |=> !addr_err_trap_q && mem_addr_q == {8'h00, $past(req_ea)};
  endproperty
  a_near: assert property (p_near) else $error("near access altered by page");
  property p_rmw;
    @(posedge ref_clk) disable iff (!rst_n)
    acc && req_rmw && req_ea[15] && data_read_page[8:0] != 9'h000 && !data_read_page[9]
    |=> mem_rd_q && mem_addr_q[23:15] == $past(data_read_page[8:0]);
  endproperty
  a_rmw: assert property (p_rmw) else $error("rmw not using read page");

endmodule // edsp_window

/* edsp_cfg.svh */
`ifndef EDSP_CFG_SVH
`define EDSP_CFG_SVH

// ==========================================================================
// Address layout
`define EDSP_EA_W        16
`define EDSP_WIN_BIT     15
`define EDSP_OFS_W       15
`define EDSP_PAGE_W      9
`define EDSP_PAGE_REG_W  10
`define EDSP_PSV_BIT     9
`define EDSP_XADDR_W     24
`define EDSP_NEAR_PAD    8'h00
`define EDSP_PAGE_ZERO   9'h000
`define EDSP_DWORD_STEP  15'h0002
`define EDSP_INT_LIMIT   24'h010000

// ==========================================================================
// Access cycle counts
`define EDSP_WR_CYC      2'h1
`define EDSP_NEAR_CYC    2'h1
`define EDSP_RD_CYC      2'h2
`define EDSP_RPT_SLOW    2'h3
`define EDSP_RPT_FAST    2'h1
`define EDSP_RPT_SLOW_N  2'h2

`endif

/* edsp_pkg.sv */
package edsp_pkg;

  // ========================================================================
  // Types
  typedef enum logic [2:0] {
    EDSP_IDLE = 3'b001,
    EDSP_BUSY = 3'b010,
    EDSP_NEXT = 3'b100
  } edsp_state_type;

  typedef enum logic [1:0] {
    EDSP_BYTE  = 2'h0,
    EDSP_WORD  = 2'h1,
    EDSP_DWORD = 2'h2
  } edsp_size_type;

endpackage

/* edsp_core_model.sv */
`timescale 1ns/100ps
// ==========================================================================
// Far-side memory port: logs each beat the block issues
module edsp_core_model (
  input  wire logic        ref_clk,
  input  wire logic        log_clr,
  input  wire logic [23:0] mem_addr_q,
  input  wire logic        mem_rd_q,
  input  wire logic        mem_wr_q,
  input  wire logic        mem_ext_q
);
  int          n_log;
  logic [25:0] log_q [0:7];

  // Entry is {write, external, address}; the log restarts with each access
  always @(posedge ref_clk) begin
    if (log_clr) begin
      n_log <= 0;
    end else if ((mem_rd_q | mem_wr_q) && n_log < 8) begin
      log_q[n_log[2:0]] <= {mem_wr_q, mem_ext_q, mem_addr_q};
      n_log <= n_log + 1;
    end
  end
endmodule // edsp_core_model

/* extended_data_space_paging_bench.sv */
`timescale 1ns/100ps
module extended_data_space_paging_bench;
  logic        ref_clk;
  logic        rstn;
  logic        req_valid;
  logic        req_write;
  logic        req_rmw;
  logic        req_repeat;
  logic [1:0]  req_size;
  logic [15:0] req_ea;
  logic [9:0]  data_read_page;
  logic [9:0]  data_write_page;
  logic        req_ready_q;
  logic [23:0] mem_addr_q;
  logic        mem_rd_q;
  logic        mem_wr_q;
  logic        mem_ext_q;
  logic        mem_psv_q;
  logic [1:0]  mem_size_q;
  logic        acc_done_q;
  logic        addr_err_trap_q;
  int          err_count;
  int          n_checks;
  int          cyc;
  logic        trap;
  logic        program_space_view;
  logic        busy;
  logic        log_clr;

  edsp_window #(.INT_LIMIT(24'h010000)) i_edsp_window (
    .ref_clk(ref_clk), .rstn(rstn), .req_valid(req_valid), .req_write(req_write),
    .req_rmw(req_rmw), .req_repeat(req_repeat), .req_size(req_size), .req_ea(req_ea),
    .data_read_page(data_read_page), .data_write_page(data_write_page),
    .req_ready_q(req_ready_q), .mem_addr_q(mem_addr_q), .mem_rd_q(mem_rd_q),
    .mem_wr_q(mem_wr_q), .mem_ext_q(mem_ext_q), .mem_psv_q(mem_psv_q),
    .mem_size_q(mem_size_q), .acc_done_q(acc_done_q), .addr_err_trap_q(addr_err_trap_q));

  edsp_core_model i_edsp_core_model (
    .ref_clk(ref_clk), .log_clr(log_clr), .mem_addr_q(mem_addr_q), .mem_rd_q(mem_rd_q),
    .mem_wr_q(mem_wr_q), .mem_ext_q(mem_ext_q));

  always #5 ref_clk = ~ref_clk;

  // ========================================================================
  // Shared tasks
  task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
    n_checks++;
    if (seen !== exp) begin
      err_count++;
      $display("Error %s expected %h seen %h", name, exp, seen);
    end
  endtask

  task automatic print_verdict;
    $display("Checks %0d mismatches %0d", n_checks, err_count);
    if (err_count == 0 && n_checks > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask

  // One access; counts cycles from acceptance to done, logs trap and view flags
  task automatic acc(input logic wr, input logic rmw, input logic rpt, input logic [1:0] sz,
                     input logic [15:0] ea, input logic [9:0] rp, input logic [9:0] wp);
    logic done;
    @(posedge ref_clk);
    log_clr         <= 1'b1;
    req_valid       <= 1'b1;
    req_write       <= wr;
    req_rmw         <= rmw;
    req_repeat      <= rpt;
    req_size        <= sz;
    req_ea          <= ea;
    data_read_page  <= rp;
    data_write_page <= wp;
    @(posedge ref_clk);
    req_valid <= 1'b0;
    log_clr   <= 1'b0;
    cyc = 0;
    trap = 1'b0;
    program_space_view = 1'b0;
    busy = 1'b0;
    done = 1'b0;
    while (!done && cyc < 12) begin
      #1;
      cyc++;
      busy |= (req_ready_q === 1'b0);
      trap |= (addr_err_trap_q === 1'b1);
      program_space_view |= (mem_psv_q === 1'b1);
      done = (acc_done_q === 1'b1);
      @(posedge ref_clk);
    end
    #1;
  endtask

  // ========================================================================
  // Scenarios
  task automatic t_near;
    acc(1'b0, 1'b0, 1'b0, 2'h1, 16'h1234, 10'h005, 10'h006);
    check("near_cycles", cyc, 1);
    check("near_addr", i_edsp_core_model.log_q[0], 26'h0001234);
    check("near_size", mem_size_q, 2'h1);
    $display("test near done");
  endtask

  task automatic t_win_read;
    acc(1'b0, 1'b0, 1'b0, 2'h1, 16'h8800, 10'h002, 10'h1ff);
    check("rd_cycles", cyc, 2);
    check("rd_addr_ext", i_edsp_core_model.log_q[0], {2'b01, 24'h010800});
    check("rd_busy", busy, 1'b1);
    check("rd_ready", req_ready_q, 1'b1);
    acc(1'b0, 1'b0, 1'b0, 2'h1, 16'h8002, 10'h001, 10'h1ff);
    check("rd_addr_int", i_edsp_core_model.log_q[0], {2'b00, 24'h008002});
    $display("test window read done");
  endtask

  task automatic t_win_write;
    acc(1'b1, 1'b0, 1'b0, 2'h0, 16'hffff, 10'h003, 10'h1ff);
    check("wr_cycles", cyc, 1);
    check("wr_addr", i_edsp_core_model.log_q[0], {2'b11, 24'hffffff});
    check("wr_beats", i_edsp_core_model.n_log, 1);
    check("wr_busy", busy, 1'b0);
    check("wr_size", mem_size_q, 2'h0);
    $display("test window write done");
  endtask

  task automatic t_trap;
    for (int w = 0; w < 2; w++) begin
      acc(w[0], 1'b0, 1'b0, 2'h1, 16'h8000, 10'h000, 10'h000);
      check("trap_flag", trap, 1'b1);
      check("trap_beats", i_edsp_core_model.n_log, 0);
    end
    $display("test page zero done");
  endtask

  task automatic t_psv;
    acc(1'b0, 1'b0, 1'b0, 2'h1, 16'h8010, 10'h202, 10'h000);
    check("psv_flag", program_space_view, 1'b1);
    check("psv_trap", trap, 1'b0);
    $display("test program view done");
  endtask

  task automatic t_dword;
    acc(1'b1, 1'b0, 1'b0, 2'h2, 16'hfffe, 10'h1ff, 10'h004);
    check("dw_beats", i_edsp_core_model.n_log, 2);
    check("dw_first", i_edsp_core_model.log_q[0], {2'b11, 24'h027ffe});
    check("dw_wrap", i_edsp_core_model.log_q[1], {2'b11, 24'h020000});
    $display("test double word done");
  endtask

  task automatic t_rmw;
    acc(1'b0, 1'b1, 1'b0, 2'h1, 16'h9000, 10'h005, 10'h006);
    check("rmw_rd", i_edsp_core_model.log_q[0], {2'b01, 24'h029000});
    check("rmw_wr", i_edsp_core_model.log_q[1], {2'b11, 24'h029000});
    $display("test read modify write done");
  endtask

  // Repeat loop carries plain reads only
  task automatic t_repeat;
    int exp_cyc [0:2] = '{3, 3, 1};
    for (int i = 0; i < 3; i++) begin
      acc(1'b0, 1'b0, 1'b1, 2'h1, 16'h8000 + 16'(2 * i), 10'h002, 10'h000);
      check("rpt_cycles", cyc, exp_cyc[i]);
    end
    acc(1'b0, 1'b0, 1'b0, 2'h1, 16'h8000, 10'h002, 10'h000);
    check("rpt_cleared", cyc, 2);
    $display("test repeat done");
  endtask

  // ========================================================================
  // Main sequence and watchdog
  initial begin
    ref_clk = 1'b0;
    rstn = 1'b0;
    req_valid = 1'b0;
    req_write = 1'b0;
    req_rmw = 1'b0;
    req_repeat = 1'b0;
    req_size = 2'h0;
    req_ea = 16'h0000;
    data_read_page = 10'h000;
    data_write_page = 10'h000;
    log_clr = 1'b0;
    err_count = 0;
    n_checks = 0;
    repeat (5) @(posedge ref_clk);
    rstn <= 1'b1;
    repeat (3) @(posedge ref_clk);
    t_near();
    t_win_read();
    t_win_write();
    t_trap();
    t_psv();
    t_dword();
    t_rmw();
    t_repeat();
    print_verdict();
  end

  initial begin
    #20000;
    err_count++;
    print_verdict();
  end
endmodule // extended_data_space_paging_bench
